// ### hdl/pds_pkg.sv
`default_nettype none
package pds_pkg;

   // ---------------------------------------------------------------
   // counter indices and sizes
   // ---------------------------------------------------------------
   localparam int NUM_TAP = 6;              // feedback plus five outputs
   localparam int NUM_DIV = 7;              // pre-scale, feedback, five outputs
   localparam int TAP_FB = 0;               // feedback tap index
   localparam int TAP_OUT0 = 1;             // first output counter tap index
   localparam int TAP_W = 3;                // eight phase taps per period
   localparam int DIV_W = 9;                // high plus low count
   localparam int CNT_W = 8;                // width of a high or low count

   // ---------------------------------------------------------------
   // target select codes
   // ---------------------------------------------------------------
   localparam logic [2:0] SEL_ALL_OUT = 3'h0;
   localparam logic [2:0] SEL_FB = 3'h1;
   localparam logic [2:0] SEL_OUT0 = 3'h2;
   localparam logic [2:0] SEL_OUT4 = 3'h6;
   localparam logic [2:0] SEL_NONE = 3'h7;

   // ---------------------------------------------------------------
   // reset values and constants
   // ---------------------------------------------------------------
   localparam logic [TAP_W-1:0] TAP_RST = 3'h0;
   localparam logic [TAP_W-1:0] TAP_ONE = 3'h1;
   localparam logic [DIV_W-1:0] DIV_ONE = 9'h001;
   localparam logic [DIV_W-1:0] DIV_RST = 9'h001;
   localparam logic DONE_RST = 1'b1;
   localparam logic DIR_UP = 1'b1;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [CNT_W-1:0] high;
      logic [CNT_W-1:0] low;
      logic bypass;
      logic odd_sel;
   } pds_cnt_cfg_s;

   typedef struct packed {
      logic dir;
      logic [2:0] sel;
   } pds_cmd_s;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ARM = 4'b0010,
      ST_BUSY = 4'b0100,
      ST_HOLD = 4'b1000
   } pds_state_e;

endpackage
`default_nettype wire

// ### hdl/pds_sync.sv
`default_nettype none
module pds_sync (
   input wire logic clk,      // destination clock
   input wire logic reset_n,  // async reset, active low
   input wire logic din,      // level from the other domain
   output logic dout          // synchronised level
);

   logic meta_ff;
   logic sync_ff;

   // first stage read only by second stage
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end

   assign dout = sync_ff;

endmodule
`default_nettype wire

// ### hdl/pds_ctrl.sv
// Operation
// - a counter whose bypass bit is 1 divides by one, and with 0 it divides normally.
// - while a counter is bypassed every other bit of its setting is ignored.
// - each completed step moves the chosen output by exactly one of eight phase taps.
// - output clocks keep running while a phase step is in progress.
// - the three-bit target select is registered on rising scan clock edges.
// - select 000 is all outputs, 001 feedback, 010 to 110 outputs 0 to 4, 111 unused.
// - direction is registered on rising scan clock edges, 1 up and 0 down.
// - the step request is sampled on falling scan clock edges.
// - at the second rising edge after sampling, direction and select are captured.
// - done drops at that edge and rises again when the shift has finished.
// - each counter setting carries a bypass bit and an odd duty select bit.
`default_nettype none
module pds_ctrl (
   input wire logic clk_sys,                                  // core clock, 50 MHz
   input wire logic reset_n,                                  // async reset, active low
   input wire logic clk_en,                                   // freezes core-side state
   input wire logic scan_clk,                                 // free-running step clock
   input wire logic step_req,                                 // phase step request
   input wire logic step_up,                                  // 1 up, 0 down
   input wire logic [2:0] step_sel,                           // target select
   input wire pds_pkg::pds_cnt_cfg_s [pds_pkg::NUM_DIV-1:0] cnt_cfg, // counter settings
   output logic phase_done,                                   // high when ready
   output logic [pds_pkg::NUM_TAP-1:0][pds_pkg::TAP_W-1:0] tap_pos, // tap per counter
   output logic [pds_pkg::NUM_DIV-1:0][pds_pkg::DIV_W-1:0] div_eff, // effective divide
   output logic [pds_pkg::NUM_DIV-1:0] odd_eff,               // half-cycle duty fix on
   output logic clk_run                                       // outputs running
);

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function automatic logic [pds_pkg::TAP_W-1:0] tap_step(
      input logic [pds_pkg::TAP_W-1:0] t,
      input logic up
   );
      // three-bit arithmetic wraps by itself
      if (up == pds_pkg::DIR_UP) begin
         tap_step = t + pds_pkg::TAP_ONE;
      end else begin
         tap_step = t - pds_pkg::TAP_ONE;
      end
   endfunction

   function automatic logic [pds_pkg::DIV_W-1:0] div_of(input pds_pkg::pds_cnt_cfg_s c);
      if (c.bypass) begin
         div_of = pds_pkg::DIV_ONE;
      end else begin
         div_of = {1'b0, c.high} + {1'b0, c.low};
      end
   endfunction

   function automatic logic tap_hit(input logic [2:0] sel, input int idx);
      logic [2:0] code;
      code = 3'(pds_pkg::SEL_OUT0 + 3'(idx - pds_pkg::TAP_OUT0));
      if (idx == pds_pkg::TAP_FB) begin
         tap_hit = (sel == pds_pkg::SEL_FB);
      end else begin
         tap_hit = (sel == pds_pkg::SEL_ALL_OUT) || (sel == code);
      end
   endfunction

   // ---------------------------------------------------------------
   // scan clock side state
   // ---------------------------------------------------------------
   typedef struct packed {
      pds_pkg::pds_state_e state;
      logic done;
      pds_pkg::pds_cmd_s cmd;
      pds_pkg::pds_cmd_s cmd_in;
      logic req_tgl;
      logic ack_seen;
   } pds_scan_s;

   pds_scan_s scan_ff;
   pds_scan_s nxt_scan;
   logic step_neg_ff;
   logic ack_sync;

   // falling-edge sample of the request
   always_ff @(negedge scan_clk or negedge reset_n) begin
      if (!reset_n) begin
         step_neg_ff <= 1'b0;
      end else begin
         step_neg_ff <= step_req;
      end
   end

   always_comb begin
      nxt_scan = scan_ff;
      nxt_scan.cmd_in.dir = step_up;
      nxt_scan.cmd_in.sel = step_sel;
      unique case (scan_ff.state)
         pds_pkg::ST_IDLE: begin
            if (step_neg_ff) begin
               nxt_scan.state = pds_pkg::ST_ARM;
            end
         end
         pds_pkg::ST_ARM: begin
            // second rising edge after the sample
            nxt_scan.cmd = scan_ff.cmd_in;
            nxt_scan.done = 1'b0;
            nxt_scan.req_tgl = ~scan_ff.req_tgl;
            nxt_scan.state = pds_pkg::ST_BUSY;
         end
         pds_pkg::ST_BUSY: begin
            if (ack_sync != scan_ff.ack_seen) begin
               nxt_scan.ack_seen = ack_sync;
               nxt_scan.done = 1'b1;
               nxt_scan.state = pds_pkg::ST_HOLD;
            end
         end
         pds_pkg::ST_HOLD: begin
            // one request, one step: wait for the request to drop
            if (!step_neg_ff) begin
               nxt_scan.state = pds_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_scan.state = pds_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge scan_clk or negedge reset_n) begin
      if (!reset_n) begin
         scan_ff <= '{state: pds_pkg::ST_IDLE, done: pds_pkg::DONE_RST,
                      cmd: '0, cmd_in: '0, req_tgl: 1'b0, ack_seen: 1'b0};
      end else begin
         scan_ff <= nxt_scan;
      end
   end

   // ---------------------------------------------------------------
   // core clock side state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic req_seen;
      logic ack_tgl;
      logic run;
      logic [pds_pkg::NUM_TAP-1:0][pds_pkg::TAP_W-1:0] tap;
      logic [pds_pkg::NUM_DIV-1:0][pds_pkg::DIV_W-1:0] div;
      logic [pds_pkg::NUM_DIV-1:0] odd;
   } pds_core_s;

   pds_core_s core_ff;
   pds_core_s nxt_core;
   logic req_sync;
   logic apply;

   pds_sync u_req_sync (
      .clk(clk_sys),
      .reset_n(reset_n),
      .din(scan_ff.req_tgl),
      .dout(req_sync)
   );

   pds_sync u_ack_sync (
      .clk(scan_clk),
      .reset_n(reset_n),
      .din(core_ff.ack_tgl),
      .dout(ack_sync)
   );

   // command word is held stable by the scan side while busy
   assign apply = (req_sync != core_ff.req_seen);

   always_comb begin
      nxt_core = core_ff;
      nxt_core.run = 1'b1;
      for (int i = 0; i < pds_pkg::NUM_DIV; i++) begin
         nxt_core.div[i] = div_of(cnt_cfg[i]);
         nxt_core.odd[i] = cnt_cfg[i].odd_sel & ~cnt_cfg[i].bypass;
      end
      if (apply) begin
         nxt_core.req_seen = req_sync;
         nxt_core.ack_tgl = ~core_ff.ack_tgl;
         for (int i = 0; i < pds_pkg::NUM_TAP; i++) begin
            // single tap move, output left running
            if (tap_hit(scan_ff.cmd.sel, i)) begin
               nxt_core.tap[i] = tap_step(core_ff.tap[i], scan_ff.cmd.dir);
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         core_ff.req_seen <= 1'b0;
         core_ff.ack_tgl <= 1'b0;
         core_ff.run <= 1'b0;
         core_ff.tap <= {pds_pkg::NUM_TAP{pds_pkg::TAP_RST}};
         core_ff.div <= {pds_pkg::NUM_DIV{pds_pkg::DIV_RST}};
         core_ff.odd <= '0;
      end else if (clk_en) begin
         core_ff <= nxt_core;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign phase_done = scan_ff.done;
   assign tap_pos = core_ff.tap;
   assign div_eff = core_ff.div;
   assign odd_eff = core_ff.odd;
   assign clk_run = core_ff.run;

   // ---------------------------------------------------------------
   // assertions, scan clock side
   // ---------------------------------------------------------------
   a_neg_sample_arm: assert property (
      @(posedge scan_clk) disable iff (!reset_n)
      (scan_ff.state == pds_pkg::ST_IDLE && step_neg_ff) |=> scan_ff.state == pds_pkg::ST_ARM)
      else $error("sampled step did not arm");

   a_done_drop_edge: assert property (
      @(posedge scan_clk) disable iff (!reset_n)
      (scan_ff.state == pds_pkg::ST_ARM) |=> !phase_done && $fell(phase_done))
      else $error("done not dropped at capture edge");

   a_cmd_capture: assert property (
      @(posedge scan_clk) disable iff (!reset_n)
      (scan_ff.state == pds_pkg::ST_ARM) |=> scan_ff.cmd == $past(scan_ff.cmd_in))
      else $error("command not captured at second edge");

   a_sel_dir_reg: assert property (
      @(posedge scan_clk) disable iff (!reset_n)
      1'b1 |=> scan_ff.cmd_in == {$past(step_up), $past(step_sel)})
      else $error("select or direction not registered");

   a_done_low_busy: assert property (
      @(posedge scan_clk) disable iff (!reset_n)
      (scan_ff.state == pds_pkg::ST_BUSY) |-> !phase_done)
      else $error("done high during shift");

   a_done_returns: assert property (
      @(posedge scan_clk) disable iff (!reset_n)
      $fell(phase_done) |-> ##[1:12] phase_done)
      else $error("done did not return high");

   a_done_idle_high: assert property (
      @(posedge scan_clk) disable iff (!reset_n)
      (scan_ff.state == pds_pkg::ST_IDLE) |-> phase_done)
      else $error("done low while idle");

   a_cmd_held_busy: assert property (
      @(posedge scan_clk) disable iff (!reset_n)
      (scan_ff.state == pds_pkg::ST_BUSY) |=> $stable(scan_ff.cmd))
      else $error("command changed during shift");

   a_one_step_hold: assert property (
      @(posedge scan_clk) disable iff (!reset_n)
      (scan_ff.state == pds_pkg::ST_HOLD && step_neg_ff) |=> scan_ff.state == pds_pkg::ST_HOLD)
      else $error("held request started a second step");

   // ---------------------------------------------------------------
   // assertions, core clock side
   // ---------------------------------------------------------------
   a_bypass_div_one: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      (clk_en && cnt_cfg[1].bypass) |=> div_eff[1] == pds_pkg::DIV_ONE)
      else $error("bypassed counter not dividing by one");

   a_bypass_odd_off: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      (clk_en && cnt_cfg[1].bypass) |=> !odd_eff[1])
      else $error("bypassed counter kept odd duty");

   a_fb_tap_step: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      (clk_en && apply && scan_ff.cmd.sel == pds_pkg::SEL_FB && scan_ff.cmd.dir)
      |=> tap_pos[pds_pkg::TAP_FB] == 3'($past(tap_pos[pds_pkg::TAP_FB]) + 3'h1))
      else $error("feedback tap did not advance by one");

   a_tap_wrap_down: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      (clk_en && apply && scan_ff.cmd.sel == pds_pkg::SEL_OUT0 && !scan_ff.cmd.dir
       && tap_pos[pds_pkg::TAP_OUT0] == 3'h0) |=> tap_pos[pds_pkg::TAP_OUT0] == 3'h7)
      else $error("tap did not wrap");

   a_sel_unused: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      (clk_en && apply && scan_ff.cmd.sel == pds_pkg::SEL_NONE) |=> $stable(tap_pos))
      else $error("unassigned select moved a tap");

   a_clk_running: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      $past(clk_en) && $past(apply) |-> clk_run)
      else $error("outputs stopped during step");

   a_div_sum: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      (clk_en && !cnt_cfg[2].bypass)
      |=> div_eff[2] == 9'({1'b0, $past(cnt_cfg[2].high)} + {1'b0, $past(cnt_cfg[2].low)}))
      else $error("counter not dividing by high plus low");

endmodule
`default_nettype wire

// ### tb/pds_core_model.sv
`default_nettype none
module pds_core_model (
   input wire logic scan_clk,     // free-running step clock
   input wire logic phase_done,   // ready from the block
   output logic step_req,         // step request
   output logic step_up,          // direction
   output logic [2:0] step_sel    // target select
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      step_req = 1'b0;
      step_up = 1'b0;
      step_sel = pds_pkg::SEL_NONE;
   end

   // ---------------------------------------------------------------
   // one full step handshake; hold keeps the request past done high
   // ---------------------------------------------------------------
   task automatic do_step(input logic up, input logic [2:0] sel, input int hold,
                          output int lat, output bit ok);
      int n;
      ok = 1'b1;
      n = 0;
      @(posedge scan_clk);
      #1;
      step_up = up;
      step_sel = sel;
      @(posedge scan_clk);
      #1;
      step_req = 1'b1;
      lat = 0;
      while (phase_done !== 1'b0 && lat < 20) begin
         @(posedge scan_clk);
         #1;
         lat++;
      end
      // captured already, so the lines no longer carry the command
      step_up = ~up;
      step_sel = ~sel;
      if (hold == 0) begin
         step_req = 1'b0;
      end
      while (phase_done !== 1'b1 && n < 40) begin
         @(posedge scan_clk);
         #1;
         n++;
      end
      repeat (hold) @(posedge scan_clk);
      #1;
      step_req = 1'b0;
      repeat (2) @(posedge scan_clk);
      if (lat >= 20 || n >= 40) begin
         ok = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ### tb/pds_ctrl_tb.sv
`default_nettype none
module pds_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic scan_clk = 1'b0;
   logic step_req;
   logic step_up;
   logic [2:0] step_sel;
   pds_pkg::pds_cnt_cfg_s [pds_pkg::NUM_DIV-1:0] cfg = '0;
   logic phase_done;
   logic [pds_pkg::NUM_TAP-1:0][pds_pkg::TAP_W-1:0] tap_pos;
   logic [pds_pkg::NUM_DIV-1:0][pds_pkg::DIV_W-1:0] div_eff;
   logic [pds_pkg::NUM_DIV-1:0] odd_eff;
   logic clk_run;
   int error_cnt = 0;
   int checks = 0;
   logic [2:0] exp_tap [pds_pkg::NUM_TAP];

   always #10 clk_sys = ~clk_sys;
   initial begin
      #7;
      forever #32 scan_clk = ~scan_clk;
   end

   pds_ctrl dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
      .scan_clk(scan_clk), .step_req(step_req), .step_up(step_up), .step_sel(step_sel),
      .cnt_cfg(cfg), .phase_done(phase_done), .tap_pos(tap_pos), .div_eff(div_eff),
      .odd_eff(odd_eff), .clk_run(clk_run));
   pds_core_model mdl (.scan_clk(scan_clk), .phase_done(phase_done),
      .step_req(step_req), .step_up(step_up), .step_sel(step_sel));

   // ---------------------------------------------------------------
   // compare and report
   // ---------------------------------------------------------------
   task automatic chk_val(input logic [8:0] got, input logic [8:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic conclude();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      repeat (4) @(negedge clk_sys);
      chk_val(9'(phase_done), 9'h001, "done in reset");
      chk_val(9'(clk_run), 9'h000, "run in reset");
      for (int i = 0; i < pds_pkg::NUM_TAP; i++) begin
         exp_tap[i] = pds_pkg::TAP_RST;
         chk_val(9'(tap_pos[i]), 9'h000, "tap in reset");
      end
      chk_val(div_eff[3], pds_pkg::DIV_RST, "div in reset");
      chk_val(9'(odd_eff), 9'h000, "odd in reset");
      repeat (4) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk_val(9'(clk_run), 9'h001, "run after reset");
   endtask

   task automatic t_divide();
      for (int i = 0; i < pds_pkg::NUM_DIV; i++) begin
         cfg[i].high = 8'h05 + 8'(i);
         cfg[i].low = 8'h03;
         cfg[i].bypass = i[0];
         cfg[i].odd_sel = 1'b1;
      end
      repeat (2) @(negedge clk_sys);
      for (int i = 0; i < pds_pkg::NUM_DIV; i++) begin
         chk_val(div_eff[i], i[0] ? 9'h001 : 9'(8 + i), "divide");
         chk_val(9'(odd_eff[i]), i[0] ? 9'h000 : 9'h001, "odd duty");
      end
      clk_en = 1'b0;
      cfg[2].high = 8'hf0;
      cfg[2].low = 8'h20;
      repeat (2) @(negedge clk_sys);
      chk_val(div_eff[2], 9'h00a, "frozen divide");
      clk_en = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk_val(div_eff[2], 9'h110, "full sum divide");
   endtask

   task automatic t_step(input logic up, input logic [2:0] sel, input int hold);
      int lat;
      bit ok;
      bit hit;
      mdl.do_step(up, sel, hold, lat, ok);
      chk_val(9'(ok), 9'h001, "handshake finished");
      if (!ok) begin
         conclude();
      end
      chk_val(9'(lat), 9'h002, "done low at second rise");
      chk_val(9'(clk_run), 9'h001, "outputs running");
      for (int i = 0; i < pds_pkg::NUM_TAP; i++) begin
         hit = (sel == pds_pkg::SEL_ALL_OUT && i >= pds_pkg::TAP_OUT0)
            || (sel == pds_pkg::SEL_FB && i == pds_pkg::TAP_FB)
            || (sel >= pds_pkg::SEL_OUT0 && sel <= pds_pkg::SEL_OUT4 && i == int'(sel) - 1);
         if (hit) begin
            exp_tap[i] = up ? exp_tap[i] + 3'h1 : exp_tap[i] - 3'h1;
         end
         chk_val(9'(tap_pos[i]), 9'(exp_tap[i]), "tap position");
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      t_reset();
      t_divide();
      for (int s = 0; s < 8; s++) begin
         t_step(1'b1, 3'(s), 0);
      end
      repeat (9) t_step(1'b0, pds_pkg::SEL_FB, 0);
      t_step(1'b0, pds_pkg::SEL_ALL_OUT, 0);
      repeat (2) t_step(1'b0, pds_pkg::SEL_OUT0, 0);
      t_step(1'b1, pds_pkg::SEL_OUT4, 5);
      t_step(1'b1, pds_pkg::SEL_OUT4, 0);
      conclude();
   end
endmodule
`default_nettype wire
